/* File: hdl/luc_regs.sv */
// lin/uart controller register block: apb slave, error flags, baud timing, response buffer
//
// Overview of operation
// - eight read-only error flags, reset to zero
// - abort command completion sets abort warning flag
// - clearing summary flag clears all eight flags
// - resync active while disable bit is zero
// - samples per bit field, default 32, 8..63
// - twelve-bit divisor scales clock to sample rate
// - transmit length from bits 7:4, max 8
// - receive length from bits 3:0, max 8
// - two identifier parity bits computed in 7:6
// - legacy mode decodes bits 5:4 as length
// - identifier width four legacy, six otherwise
// - buffer index auto-advances unless disabled
// - three-bit index selects one of eight bytes
// - data port: buffer in lin, register in uart
// - uart mode ignores lin-only fields
// - summary flag ors flags, write-one or uart read clears
// - protocol bit: zero newer, one legacy
module luc_regs
  import luc_pkg::*;
(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  // apb slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  output logic [31:0]            o_prdata,
  // protocol engine events
  input  wire logic [7:0]        i_err_set,
  input  wire logic              i_abort_done,
  input  wire logic              i_resync_edge,
  // protocol engine data path
  input  wire logic              i_rx_wr,
  input  wire logic [2:0]        i_rx_idx,
  input  wire logic [7:0]        i_rx_data,
  input  wire logic [2:0]        i_tx_idx,
  output logic [7:0]             o_tx_byte,
  output logic                   o_uart_tx_load,
  // timing and frame configuration
  output logic                   o_sample_tick,
  output logic                   o_bit_tick,
  output logic                   o_resync_en,
  output logic                   o_uart_mode,
  output logic                   o_legacy_mode,
  output logic [3:0]             o_tx_len,
  output logic [3:0]             o_rx_len,
  output logic [5:0]             o_frame_ident,
  output logic [1:0]             o_ident_parity,
  output logic                   o_error_summary
);

  typedef struct packed {
    logic                    uart_mode;
    logic                    legacy_protocol_select;
    logic [7:0]              err;
    logic                    resync_disable;
    logic [BT_SPB_W-1:0]     samples_per_bit;
    logic [DIV_W-1:0]        baud_divisor_value;
    logic [LEN_W-1:0]        tx_response_length;
    logic [LEN_W-1:0]        rx_response_length;
    logic [ID_W-1:0]         frame_ident_field;
    logic                    index_autoadvance_off;
    logic [SEL_IDX_W-1:0]    buffer_index;
    logic [BUF_DEPTH-1:0][7:0] buffer;
    logic [7:0]              uart_tx;
    logic [7:0]              uart_rx;
    logic                    tx_load;
    logic [7:0]              tx_byte;
    logic [31:0]             prdata;
    logic                    pslverr;
    logic [DIV_W-1:0]        sample_cnt;
    logic [BT_SPB_W-1:0]     bit_cnt;
    logic                    sample_tick;
    logic                    bit_tick;
  } luc_state_s;

  luc_state_s state_reg;
  luc_state_s state_next;

  function automatic logic [3:0] luc_clamp_len(input logic [3:0] len);
    luc_clamp_len = (len > LEN_MAX) ? LEN_MAX : len;
  endfunction

  function automatic logic [3:0] luc_legacy_len(input logic [1:0] code);
    case (code)
      2'h2:    luc_legacy_len = LEGACY_LEN_4;
      2'h3:    luc_legacy_len = LEGACY_LEN_8;
      default: luc_legacy_len = LEGACY_LEN_2;
    endcase
  endfunction

  function automatic logic [1:0] luc_parity(input logic [5:0] id);
    luc_parity = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[4] ^ id[2] ^ id[1] ^ id[0]};
  endfunction

  function automatic logic luc_mapped(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_CONTROL, OFS_STATUS, OFS_ERROR, OFS_BITTIME, OFS_BAUD,
      OFS_LENGTH, OFS_IDENT, OFS_BUFSEL, OFS_DATA:
        luc_mapped = 1'b1;
      default:
        luc_mapped = 1'b0;
    endcase
  endfunction

  logic        setup;
  logic        access;
  logic        wr_acc;
  logic        rd_acc;
  logic        err_clear;
  logic        data_acc;
  logic        lin_mode;
  logic [1:0]  par;
  logic [31:0] rdata;
  logic [7:0]  bt_read;
  logic [7:0]  id_read;

  assign setup    = i_psel & ~i_penable;
  assign access   = i_psel & i_penable;
  assign wr_acc   = access & i_pwrite;
  assign rd_acc   = access & ~i_pwrite;
  assign lin_mode = ~state_reg.uart_mode;
  assign par      = luc_parity(state_reg.frame_ident_field);
  assign data_acc = access & (i_paddr == OFS_DATA);

  // a write of one to the summary bit, or a uart data read, clears every flag
  assign err_clear = (wr_acc & (i_paddr == OFS_STATUS) & i_pwdata[STS_ERR_BIT])
                   | (rd_acc & (i_paddr == OFS_DATA) & state_reg.uart_mode);

  assign bt_read = {state_reg.resync_disable, 1'b0, state_reg.samples_per_bit};
  assign id_read = {(lin_mode ? par : 2'b00), state_reg.frame_ident_field};

  // read mux, sampled in the setup phase so the access phase shows flopped data
  always_comb begin
    rdata = 32'h0000_0000;
    case (i_paddr)
      OFS_CONTROL: begin
        rdata[CTL_UART_BIT]   = state_reg.uart_mode;
        rdata[CTL_LEGACY_BIT] = state_reg.legacy_protocol_select;
      end
      OFS_STATUS:  rdata[STS_ERR_BIT] = |state_reg.err;
      OFS_ERROR:   rdata[7:0] = state_reg.err;
      OFS_BITTIME: rdata[7:0] = bt_read;
      OFS_BAUD:    rdata[DIV_W-1:0] = state_reg.baud_divisor_value;
      OFS_LENGTH:  rdata[7:0] = {state_reg.tx_response_length, state_reg.rx_response_length};
      OFS_IDENT:   rdata[7:0] = id_read;
      OFS_BUFSEL:  rdata[7:0] = {4'h0, state_reg.index_autoadvance_off, state_reg.buffer_index};
      OFS_DATA: begin
        if (state_reg.uart_mode) begin
          rdata[7:0] = state_reg.uart_rx;
        end else begin
          rdata[7:0] = state_reg.buffer[state_reg.buffer_index];
        end
      end
      default:     rdata = 32'h0000_0000;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    state_next.tx_load = 1'b0;

    // apb response data captured at setup
    if (setup) begin
      state_next.prdata  = rdata;
      state_next.pslverr = ~luc_mapped(i_paddr);
    end

    // error flags: set wins over a clear in the same cycle
    state_next.err = state_reg.err & ~{8{err_clear}};
    state_next.err = state_next.err | i_err_set;
    if (i_abort_done) begin
      state_next.err[ERR_ABORT_BIT] = 1'b1;
    end

    // engine side writes received bytes
    if (i_rx_wr) begin
      if (state_reg.uart_mode) begin
        state_next.uart_rx = i_rx_data;
      end else begin
        state_next.buffer[i_rx_idx] = i_rx_data;
      end
    end
    state_next.tx_byte = state_reg.uart_mode ? state_reg.uart_tx : state_reg.buffer[i_tx_idx];

    // software writes
    if (wr_acc) begin
      case (i_paddr)
        OFS_CONTROL: begin
          state_next.uart_mode              = i_pwdata[CTL_UART_BIT];
          state_next.legacy_protocol_select = i_pwdata[CTL_LEGACY_BIT];
        end
        OFS_BITTIME: begin
          state_next.resync_disable = i_pwdata[BT_RESYNC_BIT];
          if (i_pwdata[BT_SPB_LSB +: BT_SPB_W] < SPB_MIN) begin
            state_next.samples_per_bit = SPB_MIN;
          end else begin
            state_next.samples_per_bit = i_pwdata[BT_SPB_LSB +: BT_SPB_W];
          end
        end
        // upper bits dropped; software keeps them zero
        OFS_BAUD:    state_next.baud_divisor_value = i_pwdata[DIV_W-1:0];
        OFS_LENGTH: begin
          state_next.tx_response_length = i_pwdata[LEN_TX_LSB +: LEN_W];
          state_next.rx_response_length = i_pwdata[LEN_RX_LSB +: LEN_W];
        end
        OFS_IDENT:   state_next.frame_ident_field = i_pwdata[ID_W-1:0];
        OFS_BUFSEL: begin
          state_next.index_autoadvance_off = i_pwdata[SEL_AUTO_BIT];
          state_next.buffer_index          = i_pwdata[SEL_IDX_W-1:0];
        end
        OFS_DATA: begin
          if (state_reg.uart_mode) begin
            state_next.uart_tx = i_pwdata[7:0];
            state_next.tx_load = 1'b1;
          end else begin
            state_next.buffer[state_reg.buffer_index] = i_pwdata[7:0];
          end
        end
        default: ;
      endcase
    end

    // index advance after each lin data port access while auto-advance is not disabled
    if (data_acc & lin_mode & ~state_reg.index_autoadvance_off) begin
      state_next.buffer_index = state_reg.buffer_index + 3'h1;
    end

    // sample period is divisor+1 clocks, bit period is samples_per_bit samples
    state_next.sample_tick = 1'b0;
    state_next.bit_tick    = 1'b0;
    if (state_reg.sample_cnt >= state_reg.baud_divisor_value) begin
      state_next.sample_cnt  = '0;
      state_next.sample_tick = 1'b1;
      if (state_reg.bit_cnt >= state_reg.samples_per_bit - 6'h01) begin
        state_next.bit_cnt  = '0;
        state_next.bit_tick = 1'b1;
      end else begin
        state_next.bit_cnt = state_reg.bit_cnt + 6'h01;
      end
    end else begin
      state_next.sample_cnt = state_reg.sample_cnt + 12'h001;
    end
    // an edge from the line restarts the bit when resync is allowed
    if (i_resync_edge & ~state_reg.resync_disable) begin
      state_next.sample_cnt = '0;
      state_next.bit_cnt    = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_reg                 <= '0;
      state_reg.samples_per_bit <= SPB_RESET;
      state_reg.baud_divisor_value <= DIV_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // apb outputs
  assign o_pready  = 1'b1;
  assign o_pslverr = state_reg.pslverr;
  assign o_prdata  = state_reg.prdata;

  // configuration to the protocol engine
  assign o_tx_byte       = state_reg.tx_byte;
  assign o_uart_tx_load  = state_reg.tx_load;
  assign o_sample_tick   = state_reg.sample_tick;
  assign o_bit_tick      = state_reg.bit_tick;
  assign o_resync_en     = ~state_reg.resync_disable;
  assign o_uart_mode     = state_reg.uart_mode;
  assign o_legacy_mode   = state_reg.legacy_protocol_select;
  assign o_error_summary = |state_reg.err;

  always_comb begin
    o_tx_len       = 4'h0;
    o_rx_len       = 4'h0;
    o_frame_ident  = 6'h00;
    o_ident_parity = 2'b00;
    if (lin_mode) begin
      o_ident_parity = par;
      if (state_reg.legacy_protocol_select) begin
        o_frame_ident = {2'b00, state_reg.frame_ident_field[ID_LEGACY_W-1:0]};
        o_tx_len = luc_legacy_len(state_reg.frame_ident_field[ID_LEGACY_LSB +: 2]);
        o_rx_len = luc_legacy_len(state_reg.frame_ident_field[ID_LEGACY_LSB +: 2]);
      end else begin
        o_frame_ident = state_reg.frame_ident_field;
        o_tx_len = luc_clamp_len(state_reg.tx_response_length);
        o_rx_len = luc_clamp_len(state_reg.rx_response_length);
      end
    end
  end

endmodule

/* File: hdl/luc_pkg.sv */
// register map, field positions and reset values of the lin/uart controller register block
package luc_pkg;

  localparam int unsigned ADDR_W = 12;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CONTROL   = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_ERROR     = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_BITTIME   = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_BAUD      = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_LENGTH    = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_IDENT     = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_BUFSEL    = 12'h01c;
  localparam logic [ADDR_W-1:0] OFS_DATA      = 12'h020;

  // control register fields
  localparam int unsigned CTL_UART_BIT    = 0;
  localparam int unsigned CTL_LEGACY_BIT  = 6;
  // status register field
  localparam int unsigned STS_ERR_BIT     = 3;
  // error flag positions
  localparam int unsigned ERR_ABORT_BIT   = 7;
  // bit timing fields
  localparam int unsigned BT_RESYNC_BIT   = 7;
  localparam int unsigned BT_SPB_LSB      = 0;
  localparam int unsigned BT_SPB_W        = 6;
  // baud divisor
  localparam int unsigned DIV_W           = 12;
  // response length fields
  localparam int unsigned LEN_TX_LSB      = 4;
  localparam int unsigned LEN_RX_LSB      = 0;
  localparam int unsigned LEN_W           = 4;
  localparam logic [3:0]  LEN_MAX         = 4'h8;
  // identifier fields
  localparam int unsigned ID_PAR_LSB      = 6;
  localparam int unsigned ID_LEGACY_LSB   = 4;
  localparam int unsigned ID_W            = 6;
  localparam int unsigned ID_LEGACY_W     = 4;
  // buffer select fields
  localparam int unsigned SEL_AUTO_BIT    = 3;
  localparam int unsigned SEL_IDX_W       = 3;
  localparam int unsigned BUF_DEPTH       = 8;

  // reset and limit values
  localparam logic [5:0]  SPB_RESET       = 6'h20;
  localparam logic [5:0]  SPB_MIN         = 6'h08;
  localparam logic [11:0] DIV_RESET       = 12'h000;

  // legacy length code decode results
  localparam logic [3:0]  LEGACY_LEN_2    = 4'h2;
  localparam logic [3:0]  LEGACY_LEN_4    = 4'h4;
  localparam logic [3:0]  LEGACY_LEN_8    = 4'h8;

endpackage

/* File: verif/luc_regs_checker.sv */
// assertions on the lin/uart controller register block ports
module luc_regs_checker
  import luc_pkg::*;
(
  // clock, reset and apb
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  // engine side and configuration
  input  wire logic [7:0]        i_err_set,
  input  wire logic              i_abort_done,
  input  wire logic              o_uart_tx_load,
  input  wire logic              o_sample_tick,
  input  wire logic              o_bit_tick,
  input  wire logic              o_uart_mode,
  input  wire logic              o_legacy_mode,
  input  wire logic [3:0]        o_tx_len,
  input  wire logic [3:0]        o_rx_len,
  input  wire logic [5:0]        o_frame_ident,
  input  wire logic [1:0]        o_ident_parity,
  input  wire logic              o_error_summary
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire acc = i_psel && i_penable && i_pwrite;
  wire [5:0] f = o_frame_ident;
  // a set pulse in the same cycle wins over the clear
  sequence s_clear;
    acc && i_paddr == OFS_STATUS && i_pwdata[STS_ERR_BIT] && i_err_set == 8'h00 && !i_abort_done;
  endsequence
  sequence s_uart_wr;
    acc && i_paddr == OFS_DATA && o_uart_mode;
  endsequence
  AST_SET: assert property (i_err_set != 8'h00 |=> o_error_summary)
    else $error("error flag not set");
  AST_ABORT: assert property (i_abort_done |=> o_error_summary)
    else $error("abort flag not set");
  AST_CLEAR: assert property (s_clear |=> !o_error_summary)
    else $error("flags not cleared");
  AST_TXLOAD: assert property (s_uart_wr |=> o_uart_tx_load)
    else $error("uart load missing");
  AST_PARITY: assert property (!o_uart_mode && !o_legacy_mode |->
    o_ident_parity == {~(f[1] ^ f[3] ^ f[4] ^ f[5]), f[4] ^ f[2] ^ f[1] ^ f[0]})
    else $error("parity wrong");
  AST_LEGACY: assert property (o_legacy_mode && !o_uart_mode |-> o_tx_len inside {2, 4, 8}
    && o_rx_len == o_tx_len && f[5:4] == 2'h0) else $error("legacy decode wrong");
  AST_CLAMP: assert property (!o_uart_mode |-> o_tx_len <= LEN_MAX && o_rx_len <= LEN_MAX)
    else $error("length not clamped");
  AST_UART: assert property (o_uart_mode |-> {o_tx_len, o_rx_len, f, o_ident_parity} == 0)
    else $error("uart fields not ignored");
  AST_BIT: assert property (o_bit_tick |-> o_sample_tick)
    else $error("bit tick off sample");
endmodule

bind luc_regs luc_regs_checker chk (.*);

/* File: verif/luc_engine_model.sv */
// protocol engine stand-in driving the controller's engine-side inputs
module luc_engine_model (
  input  wire logic  i_clk,
  output logic [7:0] o_err_set,
  output logic       o_abort_done,
  output logic       o_resync_edge,
  output logic       o_rx_wr,
  output logic [2:0] o_rx_idx,
  output logic [7:0] o_rx_data,
  output logic [2:0] o_tx_idx
);
  initial begin
    {o_err_set, o_abort_done, o_resync_edge, o_rx_wr, o_rx_idx, o_tx_idx} = '0;
    o_rx_data = 8'h00;
  end
  task automatic flag(input logic [7:0] v);
    o_err_set <= v;
    @(posedge i_clk);
    o_err_set <= 8'h00;
  endtask
  task automatic abort_cmd();
    o_abort_done <= 1'b1;
    @(posedge i_clk);
    o_abort_done <= 1'b0;
  endtask
  task automatic resync();
    o_resync_edge <= 1'b1;
    @(posedge i_clk);
    o_resync_edge <= 1'b0;
  endtask
  // data is inverted once the write strobe drops
  task automatic store(input logic [2:0] idx, input logic [7:0] d);
    o_rx_wr <= 1'b1;
    o_rx_idx <= idx;
    o_rx_data <= d;
    @(posedge i_clk);
    o_rx_wr <= 1'b0;
    o_rx_data <= ~d;
  endtask
endmodule

/* File: verif/luc_regs_test.sv */
// self-checking bench for the lin/uart controller register block
module luc_regs_test import luc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} luc_row_s;
  logic i_clk = 1'b0, i_nrst = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [ADDR_W-1:0] i_paddr = 12'h000;
  logic [31:0]       i_pwdata = 32'h0, o_prdata, rd;
  logic o_pready, o_pslverr, o_uart_tx_load, o_sample_tick, o_bit_tick, o_resync_en;
  logic o_uart_mode, o_legacy_mode, o_error_summary, i_abort_done, i_resync_edge, i_rx_wr, er;
  logic [7:0]        i_err_set, i_rx_data, o_tx_byte;
  logic [2:0]        i_rx_idx, i_tx_idx;
  logic [3:0]        o_tx_len, o_rx_len;
  logic [5:0]        o_frame_ident;
  logic [1:0]        o_ident_parity;
  int                fails = 0, samples_checked = 0, n;
  luc_row_s rows [12] = '{
    '{0, OFS_ERROR, 0, 32'h00, 0}, '{0, OFS_BITTIME, 0, 32'h20, 0}, '{0, OFS_BAUD, 0, 32'h0, 0},
    '{0, OFS_IDENT, 0, 32'h80, 0}, '{0, OFS_BUFSEL, 0, 32'h0, 0}, '{1, OFS_BITTIME, 32'hff, 32'hbf, 0},
    '{1, OFS_BITTIME, 32'h03, 32'h08, 0}, '{1, OFS_BAUD, 32'hffff, 32'hfff, 0},
    '{1, OFS_IDENT, 32'h3f, 32'hbf, 0}, '{1, OFS_IDENT, 32'h15, 32'h55, 0},
    '{1, OFS_LENGTH, 32'h9a, 32'h9a, 0}, '{1, 12'h040, 32'h1, 32'h0, 1}};
  always #20 i_clk = ~i_clk;
  luc_regs dut (.i_clk, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready,
    .o_pslverr, .o_prdata, .i_err_set, .i_abort_done, .i_resync_edge, .i_rx_wr, .i_rx_idx,
    .i_rx_data, .i_tx_idx, .o_tx_byte, .o_uart_tx_load, .o_sample_tick, .o_bit_tick,
    .o_resync_en, .o_uart_mode, .o_legacy_mode, .o_tx_len, .o_rx_len, .o_frame_ident,
    .o_ident_parity, .o_error_summary);
  luc_engine_model eng (.i_clk, .o_err_set(i_err_set), .o_abort_done(i_abort_done),
    .o_resync_edge(i_resync_edge), .o_rx_wr(i_rx_wr), .o_rx_idx(i_rx_idx),
    .o_rx_data(i_rx_data), .o_tx_idx(i_tx_idx));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask
  // entered just after a rising edge; leaves one idle edge behind
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1 && ++k < 50);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, x);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    results();
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    foreach (rows[k]) begin
      if (rows[k].w) wr(rows[k].a, rows[k].d);
      rdchk("register", rows[k].a, rows[k].x);
      chk("slverr", {31'h0, er}, {31'h0, rows[k].e});
    end
    chk("tx_len", o_tx_len, 32'h8);
    chk("rx_len", o_rx_len, 32'h8);
    eng.flag(8'h10);
    eng.abort_cmd();
    rdchk("errors", OFS_ERROR, 32'h90);
    rdchk("summary", OFS_STATUS, 32'h08);
    wr(OFS_STATUS, 32'h08);
    rdchk("cleared", OFS_ERROR, 32'h00);
    wr(OFS_BUFSEL, 32'h06);
    for (int k = 0; k < 3; k++) wr(OFS_DATA, 32'ha1 + k);
    wr(OFS_BUFSEL, 32'h06);
    for (int k = 0; k < 3; k++) rdchk("buffer", OFS_DATA, 32'ha1 + k);
    wr(OFS_BUFSEL, 32'h0e);
    wr(OFS_DATA, 32'hb0);
    repeat (2) rdchk("held", OFS_DATA, 32'hb0);
    eng.store(3'h2, 8'h5c);
    eng.o_tx_idx <= 3'h7;
    wr(OFS_BUFSEL, 32'h0a);
    rdchk("rx byte", OFS_DATA, 32'h5c);
    chk("tx byte", o_tx_byte, 32'ha2);
    wr(OFS_CONTROL, 32'h40);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_IDENT, 32'(k * 16 + 5));
      chk("legacy len", o_tx_len, (k < 2) ? 32'h2 : 32'h2 << (k - 1));
      chk("legacy id", o_frame_ident, 32'h5);
    end
    wr(OFS_CONTROL, 32'h01);
    chk("uart len", o_tx_len, 32'h0);
    wr(OFS_DATA, 32'h3c);
    eng.store(3'h0, 8'h77);
    eng.flag(8'h01);
    rdchk("uart rx", OFS_DATA, 32'h77);
    rdchk("uart clear", OFS_STATUS, 32'h0);
    wr(OFS_CONTROL, 32'h00);
    wr(OFS_BAUD, 32'h002);
    wr(OFS_BITTIME, 32'h08);
    eng.resync();
    n = 0;
    do @(negedge i_clk); while (o_bit_tick !== 1'b1 && ++n < 100);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_bit_tick !== 1'b1 && n < 100);
    chk("bit period", n, 32'd24);
    wr(OFS_BITTIME, 32'h88);
    chk("resync", o_resync_en, 32'h0);
    @(posedge i_clk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    chk("reset resync", o_resync_en, 32'h1);
    rdchk("reset bittime", OFS_BITTIME, 32'h20);
    rdchk("reset errors", OFS_ERROR, 32'h00);
    results();
  end
endmodule
